// file: rtl/pcm_color_path.sv
// Pixel colour mode path with host register port and palettes
// What this block does
// - Host port async; palette transfers in gaps
// - Host accesses complete even without pixels
// - Control bit picks 8 or 6 bit colour
// - Six-bit writes use bits 0-5 only
// - Six-bit colour reads return zero bits 6-7
// - Six-bit width zeroes two DAC code LSBs
// - Eight-bit read/write mode control register
// - Mode from selects plus control bits 7-6
// - Nonzero overlay index overrides every mode
// - Select 00: three ports address own palettes; with control bits 11 reserved, code zero
// - Read mask applied in palette lookup modes except the 15-bit palette index
// - Index ANDed bitwise with read mask
// - Select 01: ports drive DACs directly; with control bits 11 reserved, code zero
// - Select 10: one port indexes all palettes
// - Unselected ports ignored in single-port modes
// - Select 11: 3-3-2 bits to DAC MSBs
// - 3-3-2 mode zeroes remaining low bits
// - Select 11, bits 11: 15-bit bypass split
// - 15-bit bypass zeroes three LSBs
// - Select 10, bits 11: 15-bit palette index
`timescale 1ns/1ps
`default_nettype none
module pcm_color_path (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              pixel_mode_sel0,
    input  wire logic              pixel_mode_sel1,
    input  wire logic [3:0]        overlay_index,
    input  wire logic [7:0]        red_pixel_port,
    input  wire logic [7:0]        green_pixel_port,
    input  wire logic [7:0]        blue_pixel_port,
    input  wire logic              pix_valid,
    output var  logic              pix_ready,
    input  wire logic [2:0]        register_select,
    input  wire logic              host_rd_n,
    input  wire logic              host_wr_n,
    input  wire logic [7:0]        host_data_bus_in,
    output var  logic [7:0]        host_data_bus_out,
    output var  logic              host_data_bus_oe,
    output var  logic              dac_valid,
    input  wire logic              dac_ready,
    output var  pcm_pkg::pcm_rgb_t dac_code
);
    import pcm_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Host side state
    logic [2:0] rd_sync;
    logic [2:0] wr_sync;
    logic [2:0] rs_s1;
    logic [2:0] rs_s2;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic [2:0] rd_rs;
    logic [7:0] ctl;
    logic [7:0] mask;
    logic [7:0] addr;
    logic       ovl_sel;
    logic       commit_pend;
    logic       fetch_pend;
    pcm_phase_t phase;
    pcm_rgb_t   hold;
    logic       rd_fall;
    logic       rd_rise;
    logic       wr_rise;
    logic       idle;
    logic       wide;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic [1:0] port_sel;

    // Palette and overlay storage
    logic [7:0] pal_r [256];
    logic [7:0] pal_g [256];
    logic [7:0] pal_b [256];
    pcm_rgb_t   ovl_rgb [16];

    // Pixel pipeline state
    pcm_pin_t   s1;
    pcm_mode_t  mode_d;
    pcm_mode_t  s2_mode;
    logic       s2_v;
    logic [3:0] s2_ovl;
    pcm_rgb_t   s2_byp;
    pcm_rgb_t   s2_pal;
    pcm_rgb_t   byp_d;
    pcm_rgb_t   push_pix;
    logic [7:0] idx_r;
    logic [7:0] idx_g;
    logic [7:0] idx_b;
    logic [7:0] sel_byte;
    logic       adv;

    // Strobes cross in through three flops each, select and data through two
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_sync <= 3'h7;
            wr_sync <= 3'h7;
            rs_s1   <= 3'h0;
            rs_s2   <= 3'h0;
            d_s1    <= 8'h00;
            d_s2    <= 8'h00;
        end else begin
            rd_sync <= {rd_sync[1:0], host_rd_n};
            wr_sync <= {wr_sync[1:0], host_wr_n};
            rs_s1   <= register_select;
            rs_s2   <= rs_s1;
            d_s1    <= host_data_bus_in;
            d_s2    <= d_s1;
        end
    end

    // Edges seen only on the second and third flops
    assign rd_fall = !rd_sync[1] && rd_sync[2];
    assign rd_rise = rd_sync[1] && !rd_sync[2];
    assign wr_rise = wr_sync[1] && !wr_sync[2];
    assign idle    = rd_sync[1] && rd_sync[2] && wr_sync[1] && wr_sync[2];
    assign wide    = ctl[CTL_WIDE];
    assign port_sel = {ctl[CTL_PORT_HI], ctl[CTL_PORT_LO]};

    // Six-bit bytes sit left aligned so DAC MSBs stay meaningful
    assign wr_byte = wide ? d_s2 : {d_s2[5:0], 2'h0};

    // Colour byte of the current phase, narrowed in six-bit width
    always_comb begin
        case (phase)
            PH_GRN:  rd_byte = hold.green;
            PH_BLU:  rd_byte = hold.blue;
            default: rd_byte = hold.red;
        endcase
        if (!wide) begin
            rd_byte = {2'h0, rd_byte[7:2]};
        end
    end

    // Plain registers; reset loads the command register with CTL_RESET
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctl  <= CTL_RESET;
            mask <= MASK_RESET;
        end else if (wr_rise && rs_s2 == RS_CTL) begin
            ctl <= d_s2;
        end else if (wr_rise && rs_s2 == RS_MASK) begin
            mask <= d_s2;
        end
    end

    // Address, phase and transfers; RAM moves wait for a quiet bus
    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr        <= ADDR_RESET;
            ovl_sel     <= 1'b0;
            phase       <= PH_RED;
            commit_pend <= 1'b0;
            fetch_pend  <= 1'b0;
            hold        <= '0;
        end else if (wr_rise) begin
            case (rs_s2)
                RS_ADDR_WR, RS_ADDR_RD, RS_OVL_WR, RS_OVL_RD: begin
                    addr       <= d_s2;
                    ovl_sel    <= rs_s2[2];
                    phase      <= PH_RED;
                    fetch_pend <= rs_s2[0] && rs_s2[1];
                end
                RS_PAL, RS_OVL: begin
                    case (phase)
                        PH_RED: begin
                            hold.red <= wr_byte;
                            phase    <= PH_GRN;
                        end
                        PH_GRN: begin
                            hold.green <= wr_byte;
                            phase      <= PH_BLU;
                        end
                        default: begin
                            hold.blue   <= wr_byte;
                            phase       <= PH_RED;
                            commit_pend <= 1'b1;
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end else if (rd_rise && rd_rs[1:0] == 2'h1) begin
            case (phase)
                PH_RED:  phase <= PH_GRN;
                PH_GRN:  phase <= PH_BLU;
                default: begin
                    phase      <= PH_RED;
                    fetch_pend <= 1'b1;
                end
            endcase
        end else if (idle && commit_pend) begin
            commit_pend <= 1'b0;
            addr        <= addr + 8'h01;
        end else if (idle && fetch_pend) begin
            fetch_pend <= 1'b0;
            addr       <= addr + 8'h01;
            hold       <= ovl_sel ? ovl_rgb[addr[3:0]]
                                  : {pal_r[addr], pal_g[addr], pal_b[addr]};
        end
    end

    // Storage writes; overlay entry zero never shows, so it is inert
    always_ff @(posedge core_clk) begin
        if (idle && commit_pend && !wr_rise && !rd_rise) begin
            if (ovl_sel) begin
                ovl_rgb[addr[3:0]] <= hold;
            end else begin
                pal_r[addr] <= hold.red;
                pal_g[addr] <= hold.green;
                pal_b[addr] <= hold.blue;
            end
        end
    end

    // Read data driven for as long as the strobe is seen low
    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_data_bus_out <= 8'h00;
            host_data_bus_oe  <= 1'b0;
            rd_rs             <= 3'h0;
        end else if (rd_fall) begin
            rd_rs            <= rs_s2;
            host_data_bus_oe <= 1'b1;
            case (rs_s2)
                RS_PAL, RS_OVL: host_data_bus_out <= rd_byte;
                RS_MASK:        host_data_bus_out <= mask;
                RS_CTL:         host_data_bus_out <= ctl;
                default:        host_data_bus_out <= addr;
            endcase
        end else if (rd_rise) begin
            host_data_bus_oe <= 1'b0;
        end
    end

    // Whole pipe moves only when the buffer can take a word
    assign adv = pix_ready;

    // Stage one registers pins together with their mode selects
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1 <= '0;
        end else if (adv) begin
            s1.valid <= pix_valid;
            s1.ovl   <= overlay_index;
            s1.sel   <= {pixel_mode_sel1, pixel_mode_sel0};
            s1.pix   <= '{red_pixel_port, green_pixel_port,
                          blue_pixel_port};
        end
    end

    // Mode decode; overlays win over everything
    always_comb begin
        if (s1.ovl != 4'h0) begin
            mode_d = MD_OVL;
        end else begin
            case ({s1.sel, port_sel})
                4'h0, 4'h1, 4'h2: mode_d = MD_TRUE24;
                4'h4, 4'h5, 4'h6: mode_d = MD_BYP24;
                4'h8, 4'h9, 4'ha: mode_d = MD_PSEUDO;
                4'hb:             mode_d = MD_PAL15;
                4'hc, 4'hd, 4'he: mode_d = MD_BYP332;
                4'hf:             mode_d = MD_BYP15;
                default:          mode_d = MD_RSVD;
            endcase
        end
    end

    // Single selected port; the other two are never looked at
    always_comb begin
        case (port_sel)
            PS_GRN:  sel_byte = s1.pix.green;
            PS_BLU:  sel_byte = s1.pix.blue;
            default: sel_byte = s1.pix.red;
        endcase
    end

    // Palette indices, masked in true-colour and single-port lookup, not in 15-bit lookup
    always_comb begin
        idx_r = s1.pix.red & mask;
        idx_g = s1.pix.green & mask;
        idx_b = s1.pix.blue & mask;
        if (mode_d == MD_PSEUDO) begin
            idx_r = sel_byte & mask;
            idx_g = sel_byte & mask;
            idx_b = sel_byte & mask;
        end else if (mode_d == MD_PAL15) begin
            idx_r = {PAL15_BASE, s1.pix.red[6:2]};
            idx_g = {PAL15_BASE, s1.pix.red[1:0], s1.pix.green[7:5]};
            idx_b = {PAL15_BASE, s1.pix.green[4:0]};
        end
    end

    // Bypass codes built alongside the lookup
    always_comb begin
        byp_d = s1.pix;
        if (mode_d == MD_BYP332) begin
            byp_d = '{{sel_byte[7:5], 5'h00},
                      {sel_byte[4:2], 5'h00},
                      {sel_byte[1:0], 6'h00}};
        end else if (mode_d == MD_BYP15) begin
            byp_d = '{{s1.pix.red[6:2], 3'h0},
                      {s1.pix.red[1:0], s1.pix.green[7:5], 3'h0},
                      {s1.pix.green[4:0], 3'h0}};
        end
    end

    // Stage two: lookup and bypass both take one cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s2_v    <= 1'b0;
            s2_mode <= MD_RSVD;
            s2_ovl  <= 4'h0;
            s2_byp  <= '0;
            s2_pal  <= '0;
        end else if (adv) begin
            s2_v    <= s1.valid;
            s2_mode <= mode_d;
            s2_ovl  <= s1.ovl;
            s2_byp  <= byp_d;
            s2_pal  <= '{pal_r[idx_r], pal_g[idx_g], pal_b[idx_b]};
        end
    end

    // Final choice, then width trimming of the low bits
    always_comb begin
        case (s2_mode)
            MD_OVL:                        push_pix = ovl_rgb[s2_ovl];
            MD_TRUE24, MD_PSEUDO, MD_PAL15: push_pix = s2_pal;
            MD_BYP24, MD_BYP332, MD_BYP15:  push_pix = s2_byp;
            default:                       push_pix = '0;
        endcase
        if (!wide) begin
            push_pix.red[1:0]   = 2'h0;
            push_pix.green[1:0] = 2'h0;
            push_pix.blue[1:0]  = 2'h0;
        end
    end

    // Receiver stall backs up through this buffer to pix_ready
    pcm_pair_buf #(
        .WIDTH ($bits(pcm_rgb_t))
    ) u_buf (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (s2_v && adv),
        .in_ready  (pix_ready),
        .in_data   (push_pix),
        .out_valid (dac_valid),
        .out_ready (dac_ready),
        .out_data  (dac_code)
    );

    // Checks
    sequence s_take;
        adv && pix_valid;
    endsequence
    sequence s_step;
        adv ##1 adv;
    endsequence
    property p_latency;
        s_take ##0 s_step |=> s2_v;
    endproperty
    a_latency: assert property (p_latency) else $error("pixel lost");
    property p_byp24;
        adv && s1.valid && mode_d == MD_BYP24 |=> s2_byp == $past(s1.pix);
    endproperty
    a_byp24: assert property (p_byp24) else $error("bypass24 bad");
    property p_332;
        s2_mode == MD_BYP332 |-> push_pix.red[4:0] == 5'h00 &&
            push_pix.green[4:0] == 5'h00 && push_pix.blue[5:0] == 6'h00;
    endproperty
    a_332: assert property (p_332) else $error("332 low bits");
    property p_15;
        adv && mode_d == MD_BYP15 |=>
            s2_byp.red[7:3] == $past(s1.pix.red[6:2]) &&
            s2_byp.blue == {$past(s1.pix.green[4:0]), 3'h0};
    endproperty
    a_15: assert property (p_15) else $error("15-bit split");
    property p_ovl;
        adv && s1.ovl != 4'h0 |=> s2_mode == MD_OVL;
    endproperty
    a_ovl: assert property (p_ovl) else $error("overlay lost");
    property p_rsvd;
        s2_mode == MD_RSVD |-> push_pix == '0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved nonzero");
    property p_six;
        !wide |-> push_pix.red[1:0] == 2'h0 && push_pix.blue[1:0] == 2'h0;
    endproperty
    a_six: assert property (p_six) else $error("six-bit LSBs");
    property p_rdzero;
        rd_fall && rs_s2 == RS_PAL && !wide |=> host_data_bus_out[7:6] == 2'h0;
    endproperty
    a_rdzero: assert property (p_rdzero) else $error("read bits 6-7");
    property p_ctl;
        wr_rise && rs_s2 == RS_CTL |=> ctl == $past(d_s2);
    endproperty
    a_ctl: assert property (p_ctl) else $error("control write");
    property p_mask;
        mode_d == MD_TRUE24 |-> idx_g == (s1.pix.green & mask);
    endproperty
    a_mask: assert property (p_mask) else $error("mask not applied");
endmodule
`default_nettype wire

// file: rtl/pcm_pair_buf.sv
// Two-entry output buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pcm_pair_buf #(
    parameter int WIDTH = 24
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    logic [1:0]       count;
    logic [1:0]       next_count;
    logic [WIDTH-1:0] spare;
    logic             push;
    logic             pop;

    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    // Occupancy after this edge
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    // Flags registered from next occupancy so ready is exact
    always_ff @(posedge core_clk) begin
        if (reset) begin
            count     <= 2'h0;
            out_valid <= 1'b0;
            in_ready  <= 1'b1;
        end else begin
            count     <= next_count;
            out_valid <= (next_count != 2'h0);
            in_ready  <= (next_count != 2'h2);
        end
    end

    // Head entry feeds the output, spare catches a stalled word
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_data <= '0;
            spare    <= '0;
        end else if (push && (!pop || count == 2'h1)) begin
            if (count == 2'h0 || (pop && count == 2'h1)) begin
                out_data <= in_data;
            end else begin
                spare <= in_data;
            end
        end else if (pop && count == 2'h2) begin
            out_data <= spare;
            if (push) begin
                spare <= in_data;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/pcm_pkg.sv
// Shared types and constants for the pixel colour mode path
package pcm_pkg;
    // Host register selects
    localparam logic [2:0] RS_ADDR_WR = 3'h0;
    localparam logic [2:0] RS_PAL     = 3'h1;
    localparam logic [2:0] RS_MASK    = 3'h2;
    localparam logic [2:0] RS_ADDR_RD = 3'h3;
    localparam logic [2:0] RS_OVL_WR  = 3'h4;
    localparam logic [2:0] RS_OVL     = 3'h5;
    localparam logic [2:0] RS_CTL     = 3'h6;
    localparam logic [2:0] RS_OVL_RD  = 3'h7;
    // Control register fields
    localparam int CTL_PORT_HI = 7;
    localparam int CTL_PORT_LO = 6;
    localparam int CTL_WIDE    = 1;
    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    // Port select codes from the two high control bits
    localparam logic [1:0] PS_RED = 2'h0;
    localparam logic [1:0] PS_GRN = 2'h1;
    localparam logic [1:0] PS_BLU = 2'h2;
    localparam logic [1:0] PS_15B = 2'h3;
    // Upper address bits for the 15-bit palette window
    localparam logic [2:0] PAL15_BASE = 3'h7;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pcm_rgb_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] ovl;
        logic [1:0] sel;
        pcm_rgb_t   pix;
    } pcm_pin_t;

    // Host colour byte phase, counts modulo three
    typedef enum logic [2:0] {
        PH_RED = 3'b001,
        PH_GRN = 3'b010,
        PH_BLU = 3'b100
    } pcm_phase_t;

    typedef enum logic [7:0] {
        MD_OVL    = 8'b0000_0001,
        MD_TRUE24 = 8'b0000_0010,
        MD_BYP24  = 8'b0000_0100,
        MD_PSEUDO = 8'b0000_1000,
        MD_PAL15  = 8'b0001_0000,
        MD_BYP332 = 8'b0010_0000,
        MD_BYP15  = 8'b0100_0000,
        MD_RSVD   = 8'b1000_0000
    } pcm_mode_t;
endpackage

// file: tb/pcm_gfx_model.sv
// Graphics controller model driving the pixel side
`timescale 1ns/1ps
`default_nettype none
module pcm_gfx_model (
    input  wire logic       core_clk,
    input  wire logic       pix_ready,
    output var  logic       pixel_mode_sel0,
    output var  logic       pixel_mode_sel1,
    output var  logic [3:0] overlay_index,
    output var  logic [7:0] red_pixel_port,
    output var  logic [7:0] green_pixel_port,
    output var  logic [7:0] blue_pixel_port,
    output var  logic       pix_valid,
    output var  logic       stuck
);
    import pcm_pkg::*;

    // Idle at time zero
    initial begin
        {pixel_mode_sel1, pixel_mode_sel0} = 2'h0;
        overlay_index = 4'h0;
        {red_pixel_port, green_pixel_port, blue_pixel_port} = 24'h0;
        pix_valid = 1'b0;
        stuck = 1'b0;
    end

    // Offer one pixel; selects travel with it and hold until taken
    task automatic send(input pcm_pin_t p);
        int k;
        @(negedge core_clk);
        {pixel_mode_sel1, pixel_mode_sel0} = p.sel;
        overlay_index = p.ovl;
        {red_pixel_port, green_pixel_port, blue_pixel_port} = p.pix;
        pix_valid = 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge core_clk);
            if (pix_ready === 1'b1) break;
        end
        if (k == 200) stuck = 1'b1;
    endtask

    // Released lines flip so stale data never looks valid
    task automatic idle();
        @(negedge core_clk);
        pix_valid = 1'b0;
        overlay_index = ~overlay_index;
        red_pixel_port = ~red_pixel_port;
        green_pixel_port = ~green_pixel_port;
        blue_pixel_port = ~blue_pixel_port;
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the pixel colour mode path
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcm_pkg::*;
    logic        core_clk, reset, sel0, sel1, pix_valid, pix_ready, stuck;
    logic        host_rd_n, host_wr_n, host_data_bus_oe, dac_valid;
    logic        dac_ready;
    logic [3:0]  overlay_index;
    logic [7:0]  red, green, blue, host_data_bus_in, host_data_bus_out;
    logic [7:0]  d, ctl;
    logic [2:0]  register_select;
    logic [23:0] pal0, ovl3;
    logic [31:0] rng, rdy_rng;
    pcm_rgb_t    dac_code;
    pcm_rgb_t    q[$];
    pcm_pin_t    p;
    int          num_errors, samples_checked, b, i;

    pcm_color_path dut (.core_clk(core_clk), .reset(reset),
        .pixel_mode_sel0(sel0), .pixel_mode_sel1(sel1),
        .overlay_index(overlay_index), .red_pixel_port(red),
        .green_pixel_port(green), .blue_pixel_port(blue),
        .pix_valid(pix_valid), .pix_ready(pix_ready),
        .register_select(register_select), .host_rd_n(host_rd_n),
        .host_wr_n(host_wr_n), .host_data_bus_in(host_data_bus_in),
        .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe(host_data_bus_oe), .dac_valid(dac_valid),
        .dac_ready(dac_ready), .dac_code(dac_code));

    pcm_gfx_model gc (.core_clk(core_clk), .pix_ready(pix_ready),
        .pixel_mode_sel0(sel0), .pixel_mode_sel1(sel1),
        .overlay_index(overlay_index), .red_pixel_port(red),
        .green_pixel_port(green), .blue_pixel_port(blue),
        .pix_valid(pix_valid), .stuck(stuck));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Expected code; every lookup lands on an entry loaded with pal0
    function automatic logic [23:0] expect_code(input logic [7:0] c,
                                                input pcm_pin_t p);
        logic [7:0]  x;
        logic [23:0] e;
        x = c[7:6] == 2'h0 ? p.pix.red
          : c[7:6] == 2'h1 ? p.pix.green : p.pix.blue;
        case (p.sel)
            2'h0: e = c[7:6] == 2'h3 ? 24'h0 : pal0;
            2'h1: e = c[7:6] == 2'h3 ? 24'h0 : p.pix;
            2'h2: e = pal0;
            default: e = c[7:6] == 2'h3
                ? {p.pix.red[6:2], 3'h0, p.pix.red[1:0],
                   p.pix.green[7:5], 3'h0, p.pix.green[4:0], 3'h0}
                : {x[7:5], 5'h0, x[4:2], 5'h0, x[1:0], 6'h0};
        endcase
        if (p.ovl != 4'h0) e = ovl3;
        if (!c[1]) e = e & 24'hfcfcfc;
        return e;
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Select and data settle well before the strobe rises
    task automatic host_wr(input logic [2:0] rs, input logic [7:0] v);
        @(negedge core_clk);
        register_select = rs;
        host_data_bus_in = v;
        host_wr_n = 1'b0;
        repeat (4) @(negedge core_clk);
        host_wr_n = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask

    task automatic host_rd(input logic [2:0] rs, output logic [7:0] v);
        int k;
        @(negedge core_clk);
        register_select = rs;
        host_rd_n = 1'b0;
        for (k = 0; k < 12 && host_data_bus_oe !== 1'b1; k++)
            @(negedge core_clk);
        if (k == 12) num_errors++;
        @(negedge core_clk);
        v = host_data_bus_out;
        host_rd_n = 1'b1;
        for (k = 0; k < 12 && host_data_bus_oe !== 1'b0; k++)
            @(negedge core_clk);
        if (k == 12) num_errors++;
        repeat (4) @(negedge core_clk);
    endtask

    task automatic drain();
        int k;
        gc.idle();
        for (k = 0; k < 500 && q.size() != 0; k++) @(negedge core_clk);
        if (k == 500) num_errors++;
    endtask

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0 && stuck === 1'b0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Receiver stalls one cycle in four
    always @(negedge core_clk) begin
        rdy_rng = xs(rdy_rng);
        dac_ready = ~reset & (rdy_rng[1:0] != 2'h0);
    end

    // Words leave in the order pixels went in
    always @(posedge core_clk)
        if (!reset && dac_valid === 1'b1 && dac_ready === 1'b1) begin
            if (q.size() == 0) check(dac_code, ~dac_code);
            else check(dac_code, q.pop_front());
        end

    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end

    initial begin
        rng = 32'h8ba3;
        rdy_rng = 32'h8ba3;
        num_errors = 0;
        samples_checked = 0;
        reset = 1'b1;
        {host_rd_n, host_wr_n} = 2'h3;
        register_select = 3'h0;
        host_data_bus_in = 8'h00;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk) reset = 1'b0;
        host_rd(RS_CTL, d);
        check(24'(d), 24'(CTL_RESET));
        host_rd(RS_MASK, d);
        check(24'(d), 24'(MASK_RESET));
        for (i = 0; i < 3; i++) begin
            rng = xs(rng);
            host_wr(RS_CTL, rng[7:0]);
            host_rd(RS_CTL, d);
            check(24'(d), 24'(rng[7:0]));
        end
        // Control set to eight-bit width before the palette loads
        host_wr(RS_CTL, 8'h02);
        rng = xs(rng);
        pal0 = rng[23:0];
        host_wr(RS_ADDR_WR, 8'h00);
        for (i = 2; i >= 0; i--) host_wr(RS_PAL, pal0[i*8 +: 8]);
        // Zero 15-bit fields index the bottom of the upper window
        host_wr(RS_ADDR_WR, {PAL15_BASE, 5'h00});
        for (i = 2; i >= 0; i--) host_wr(RS_PAL, pal0[i*8 +: 8]);
        host_wr(RS_MASK, 8'h00);
        // Six-bit loads keep data bits 5:0 only
        host_wr(RS_CTL, 8'h00);
        rng = xs(rng);
        host_wr(RS_OVL_WR, 8'h03);
        for (i = 2; i >= 0; i--) host_wr(RS_OVL, rng[i*8 +: 8]);
        ovl3 = (rng[23:0] & 24'h3f3f3f) << 2;
        host_wr(RS_ADDR_RD, 8'h00);
        for (i = 2; i >= 0; i--) begin
            host_rd(RS_PAL, d);
            check(24'(d), 24'({2'h0, pal0[i*8+2 +: 6]}));
        end
        // Every port select in both widths, random modes back to back
        for (b = 0; b < 8; b++) begin
            ctl = {b[1:0], 4'h0, b[2], 1'b0};
            host_wr(RS_CTL, ctl);
            for (i = 0; i < 40; i++) begin
                rng = xs(rng);
                p = rng[30:0];
                p.ovl = rng[31:29] == 3'h0 ? 4'h3 : 4'h0;
                if (ctl[7:6] == 2'h3 && p.sel == 2'h2) begin
                    p.pix.red[6:0] = 7'h00;
                    p.pix.green = 8'h00;
                end
                q.push_back(expect_code(ctl, p));
                gc.send(p);
            end
            drain();
        end
        wrap_up();
    end
endmodule
`default_nettype wire
